// ===== design/sec_bus_arbiter.sv
// arbiter for the secondary bus: internal request plus eight external masters
`timescale 1ns/1ps
module sec_bus_arbiter
  import arb_pkg::*;
#(
  parameter int NREQ = 9
)(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic arbiter_select_strap,
  input wire logic [NREQ-1:0] req_l,
  input wire logic frame_l,
  input wire logic irdy_l,
  output logic [NREQ-1:0] gnt_l
);
  //-------------------------------------------------------------
  // pin synchronisers (three stages, agree on last two)
  //-------------------------------------------------------------
  logic [NREQ-1:0] req_s1_reg, req_s2_reg, req_s3_reg, req_reg;
  logic [2:0] frm_s_reg, irdy_s_reg, strap_s_reg;
  logic frame_reg, irdy_reg, strap_reg, frame_prev_reg;
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      req_s1_reg <= '1;
      req_s2_reg <= '1;
      req_s3_reg <= '1;
      req_reg <= '1;
      frm_s_reg <= 3'h7;
      irdy_s_reg <= 3'h7;
      strap_s_reg <= 3'h0;
      frame_reg <= 1'b1;
      irdy_reg <= 1'b1;
      strap_reg <= 1'b0;
      frame_prev_reg <= 1'b1;
    end
    else
    begin
      req_s1_reg <= req_l;
      req_s2_reg <= req_s1_reg;
      req_s3_reg <= req_s2_reg;
      for (int i = 0; i < NREQ; i++)
        if (req_s2_reg[i] == req_s3_reg[i])
          req_reg[i] <= req_s3_reg[i];
      frm_s_reg <= {frm_s_reg[1:0], frame_l};
      irdy_s_reg <= {irdy_s_reg[1:0], irdy_l};
      strap_s_reg <= {strap_s_reg[1:0], arbiter_select_strap};
      if (frm_s_reg[1] == frm_s_reg[2])
        frame_reg <= frm_s_reg[2];
      if (irdy_s_reg[1] == irdy_s_reg[2])
        irdy_reg <= irdy_s_reg[2];
      if (strap_s_reg[1] == strap_s_reg[2])
        strap_reg <= strap_s_reg[2];
      frame_prev_reg <= frame_reg;
    end
  end

  //-------------------------------------------------------------
  // configuration register
  //-------------------------------------------------------------
  logic [8:0] en_reg, prio_reg;
  logic tmo_en_reg, refresh_reg, toggle_reg;
  logic [7:0] fair_reg;
  logic [31:0] rdata_reg;
  wire hit = (reg_addr == ARB_REG_OFFSET);
  wire [31:0] cfg_word = {1'b0, prio_reg, 1'b0, toggle_reg, fair_reg, refresh_reg,
                          tmo_en_reg, strap_reg, en_reg};
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      en_reg <= EN_RESET;
      prio_reg <= PRIO_RESET;
      tmo_en_reg <= 1'b0;
      refresh_reg <= 1'b0;
      fair_reg <= FAIR_RESET;
      toggle_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end
    else
    begin
      if (reg_wr && hit)
      begin
        en_reg <= reg_wdata[EN_LSB+:9];
        tmo_en_reg <= reg_wdata[TMO_EN_BIT];
        refresh_reg <= reg_wdata[REFRESH_BIT];
        fair_reg <= reg_wdata[FAIR_LSB+:8];
        toggle_reg <= reg_wdata[TOGGLE_BIT];
        prio_reg <= reg_wdata[PRIO_LSB+:9];
      end
      rdata_reg <= (reg_rd && hit) ? cfg_word : 32'h0000_0000;
    end
  end
  assign reg_rdata = rdata_reg;

  //-------------------------------------------------------------
  // requester selection
  //-------------------------------------------------------------
  logic [NREQ-1:0] broken_reg, served_reg, last_reg;
  logic [NREQ-1:0] gnt_reg;
  arb_state_t state_reg;
  wire [NREQ-1:0] active_req = ~req_reg & en_reg & ~broken_reg;
  wire [NREQ-1:0] hi_req = active_req & prio_reg;
  wire [NREQ-1:0] cand = (|hi_req) ? hi_req : active_req;
  // round robin: rotate past last winner
  logic [NREQ-1:0] pick;
  always_comb
  begin
    logic found;
    int idx;
    found = 1'b0;
    pick = '0;
    idx = 0;
    for (int k = 0; k < NREQ; k++)
      if (last_reg[k])
        idx = k;
    for (int k = 1; k <= NREQ; k++)
    begin
      if (!found && cand[(idx + k) % NREQ])
      begin
        pick[(idx + k) % NREQ] = 1'b1;
        found = 1'b1;
      end
    end
  end

  //-------------------------------------------------------------
  // grant control
  //-------------------------------------------------------------
  logic [4:0] tmo_cnt_reg;
  logic [7:0] fair_cnt_reg;
  logic fair_armed_reg;
  logic [1:0] tog_cnt_reg;
  logic tog_done_reg;
  wire bus_idle = frame_reg && irdy_reg;
  wire frame_fall = frame_prev_reg && !frame_reg;
  // a grant also ends when software disables its owner
  wire owner_req = |(gnt_reg & ~req_reg & en_reg);
  wire others_req = |(active_req & ~gnt_reg);
  wire tmo_hit = tmo_en_reg && (state_reg == ST_WAIT) && bus_idle &&
                 (tmo_cnt_reg == 5'(TMO_CYCLES - 1));
  // zero fairness holds until owner releases
  wire fair_out = (fair_reg != 8'h00) && fair_armed_reg && others_req &&
                  (fair_cnt_reg == 8'h00);
  wire release_gnt = tmo_hit || !owner_req || fair_out;
  // all other enabled masters served since the break
  wire all_served = &(served_reg | ~en_reg | broken_reg);
  wire tog_low = toggle_reg && (state_reg == ST_BUSY) &&
                 (tog_cnt_reg == 2'(TOGGLE_DELAY)) && !tog_done_reg;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= ST_IDLE;
      gnt_reg <= '0;
      last_reg <= '0;
      broken_reg <= '0;
      served_reg <= '0;
      tmo_cnt_reg <= 5'h00;
      fair_cnt_reg <= 8'h00;
      fair_armed_reg <= 1'b0;
      tog_cnt_reg <= 2'h0;
      tog_done_reg <= 1'b0;
    end
    else
    begin
      unique case (state_reg)
        ST_IDLE:
        begin
          if (|pick)
          begin
            gnt_reg <= pick;
            last_reg <= pick;
            served_reg <= served_reg | pick;
            fair_cnt_reg <= fair_reg;
            fair_armed_reg <= 1'b0;
            tmo_cnt_reg <= 5'h00;
            tog_cnt_reg <= 2'h0;
            tog_done_reg <= 1'b0;
            state_reg <= ST_WAIT;
          end
        end
        ST_WAIT:
        begin
          if (bus_idle)
            tmo_cnt_reg <= tmo_cnt_reg + 5'h01;
          if (tmo_hit)
          begin
            gnt_reg <= '0;
            broken_reg <= broken_reg | gnt_reg;
            served_reg <= '0;
            state_reg <= ST_IDLE;
          end
          else if (!owner_req)
          begin
            gnt_reg <= '0;
            state_reg <= ST_IDLE;
          end
          else if (frame_fall)
          begin
            fair_armed_reg <= 1'b1;
            state_reg <= ST_BUSY;
          end
        end
        ST_BUSY:
        begin
          if (others_req && fair_cnt_reg != 8'h00)
            fair_cnt_reg <= fair_cnt_reg - 8'h01;
          if (tog_cnt_reg != 2'(TOGGLE_DELAY))
            tog_cnt_reg <= tog_cnt_reg + 2'h1;
          else
            tog_done_reg <= 1'b1;
          if (release_gnt)
          begin
            gnt_reg <= '0;
            state_reg <= ST_IDLE;
          end
        end
        default:
          state_reg <= ST_IDLE;
      endcase
      // broken masters: refresh or stay ignored
      if (refresh_reg && all_served && (|broken_reg) && state_reg != ST_WAIT)
        broken_reg <= '0;
    end
  end
  // grant held, or dropped one clock when toggling
  assign gnt_l = tog_low ? '1 : ~gnt_reg;

  //-------------------------------------------------------------
  // checks: grant ownership
  //-------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  chk_one_hot_grant: assert property ($onehot0(~gnt_l))
    else $error("more than one grant active");
  chk_grant_enabled: assert property ((~gnt_l & ~en_reg) == '0 || $changed(en_reg))
    else $error("grant to disabled requester");
  chk_grant_gap: assert property (
    (gnt_reg != '0 && $past(gnt_reg) != '0) |-> gnt_reg == $past(gnt_reg))
    else $error("grant moved without an idle cycle");
  chk_internal_excluded: assert property (
    $rose(gnt_reg[0]) |-> $past(en_reg[0]))
    else $error("internal request granted while disabled");
  chk_master_excluded: assert property (
    ((gnt_reg & ~$past(gnt_reg)) & ~$past(en_reg)) == '0)
    else $error("master granted while disabled");
  chk_priority_first: assert property (
    (state_reg == ST_IDLE && hi_req != '0) |=> (gnt_reg & ~$past(hi_req)) == '0)
    else $error("low priority master won over high");
  //-------------------------------------------------------------
  // checks: register port
  //-------------------------------------------------------------
  // strap shown on reads
  chk_strap_read: assert property (
    (reg_rd && hit) |=> reg_rdata[STRAP_BIT] == $past(strap_reg))
    else $error("strap bit wrong");
  chk_enable_write: assert property (
    (reg_wr && hit) |=> en_reg == $past(reg_wdata[EN_LSB+:9]))
    else $error("enable write lost");
  //-------------------------------------------------------------
  // checks: broken masters and timeout
  //-------------------------------------------------------------
  // idle cycles counted
  chk_tmo_count: assert property (
    (state_reg == ST_WAIT && bus_idle && !tmo_hit && !frame_fall && owner_req)
    |=> tmo_cnt_reg == $past(tmo_cnt_reg) + 5'h01)
    else $error("timeout counter stalled");
  chk_tmo_drop: assert property (tmo_hit |=> gnt_reg == '0)
    else $error("grant kept after timeout");
  chk_tmo_mark: assert property (
    tmo_hit |=> (broken_reg & $past(gnt_reg)) == $past(gnt_reg))
    else $error("timed out master not marked broken");
  chk_broken_skipped: assert property (
    ((gnt_reg & ~$past(gnt_reg)) & $past(broken_reg)) == '0)
    else $error("broken master granted");
  chk_broken_kept: assert property (
    !refresh_reg |=> ($past(broken_reg) & ~broken_reg) == '0)
    else $error("broken master released with refresh off");
  chk_refresh_clear: assert property (
    (refresh_reg && all_served && broken_reg != '0 && state_reg != ST_WAIT)
    |=> broken_reg == '0)
    else $error("broken state not refreshed");
  //-------------------------------------------------------------
  // checks: fairness and toggling
  //-------------------------------------------------------------
  // reload on new grant
  chk_fair_reload: assert property (
    $rose(state_reg == ST_WAIT) |-> fair_cnt_reg == $past(fair_reg))
    else $error("fairness not reloaded");
  chk_fair_waits: assert property (
    state_reg == ST_WAIT |=> fair_cnt_reg == $past(fair_cnt_reg))
    else $error("fairness counter moved before frame");
  chk_fair_step: assert property (
    (state_reg == ST_BUSY && others_req && fair_cnt_reg != 8'h00)
    |=> fair_cnt_reg == $past(fair_cnt_reg) - 8'h01)
    else $error("fairness counter did not step");
  chk_fair_release: assert property (
    (state_reg == ST_BUSY && fair_out) |=> gnt_reg == '0)
    else $error("grant kept after fairness expiry");
  chk_zero_fair_hold: assert property (
    (fair_reg == 8'h00 && state_reg == ST_BUSY && owner_req && !tmo_hit)
    |=> gnt_reg != '0 || $changed(fair_reg))
    else $error("grant removed with zero fairness");
  chk_no_toggle: assert property (
    (!toggle_reg && gnt_reg != '0) |-> gnt_l == ~gnt_reg)
    else $error("grant toggled while disabled");
  chk_toggle_pulse: assert property (tog_low |=> !tog_low)
    else $error("toggle pulse longer than one clock");
  chk_toggle_late: assert property (
    tog_low |-> $past(state_reg == ST_BUSY, 2))
    else $error("toggle pulse too early");
  //-------------------------------------------------------------
  // coverage of the main scenarios
  //-------------------------------------------------------------
  cov_grant: cover property (state_reg == ST_IDLE ##1 state_reg == ST_WAIT);
  cov_timeout: cover property (tmo_hit);
  cov_fair_out: cover property (fair_out);
  cov_toggle: cover property (tog_low);
  cov_refresh: cover property (refresh_reg && all_served && broken_reg != '0);
endmodule

// ===== dv/pci_masters.sv
// behavioural bus masters on the secondary side of the arbiter
`timescale 1ns/1ps
module pci_masters
  import arb_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [8:0] want,
  input wire logic [8:0] dead,
  input wire logic [7:0] blen,
  input wire logic [8:0] gnt_l,
  output logic [8:0] req_l,
  output logic frame_l,
  output logic irdy_l,
  output logic [8:0] served
);
  logic [7:0] cnt;
  logic [3:0] own;
  logic [3:0] gi;
  wire logic go;
  always_comb
  begin
    gi = 4'h0;
    for (int i = 0; i < 9; i++)
      if (!gnt_l[i])
        gi = 4'(i);
  end
  // a dead master sits on its grant and never starts a frame
  assign go = (gnt_l != 9'h1FF) && !dead[gi] && !served[gi] && frame_l;
  assign irdy_l = frame_l;
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
    begin
      req_l <= 9'h1FF;
      frame_l <= 1'b1;
      served <= 9'h000;
      cnt <= 8'h00;
      own <= 4'h0;
    end
    else
    begin
      req_l <= ~(want & ~served);
      served <= served & want;
      if (cnt != 8'h00)
      begin
        cnt <= cnt - 8'h01;
        if (cnt == 8'h01)
        begin
          frame_l <= 1'b1;
          served[own] <= 1'b1;
        end
      end
      else if (go)
      begin
        frame_l <= 1'b0;
        cnt <= blen;
        own <= gi;
      end
    end
endmodule

// ===== dv/tb_top.sv
// self-checking bench for the secondary bus arbiter
`timescale 1ns/1ps
module tb_top;
  import arb_pkg::*;
  logic core_clk, rst, reg_wr, reg_rd, strap, frame_l, irdy_l;
  logic [7:0] reg_addr, blen;
  logic [31:0] reg_wdata, reg_rdata;
  logic [8:0] req_l, gnt_l, want, dead, served, en_sh, pg;
  wire logic [9:0] bv = {frame_l, gnt_l};
  int seed, bad_count, n_tests, t, r;
  sec_bus_arbiter dut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .arbiter_select_strap(strap), .req_l(req_l), .frame_l(frame_l), .irdy_l(irdy_l),
    .gnt_l(gnt_l));
  pci_masters bus (.core_clk(core_clk), .rst(rst), .want(want), .dead(dead),
    .blen(blen), .gnt_l(gnt_l), .req_l(req_l), .frame_l(frame_l), .irdy_l(irdy_l),
    .served(served));
  always #12.5 core_clk = ~core_clk;
  function automatic logic [31:0] cfg(logic [8:0] en, logic [3:0] m, logic [7:0] fr,
    logic [8:0] pr);
    return {1'b0, pr, 1'b0, m[2], fr, m[1], m[0], 1'b0, en};
  endfunction
  // read-only bits 9, 21, 31: strap level or zero
  function automatic logic [31:0] rx(logic [31:0] w);
    return (w & 32'h7FDF_FDFF) | {22'h0, strap, 9'h0};
  endfunction
  task automatic chk(logic [31:0] g, logic [31:0] e);
    n_tests++;
    if (g !== e)
    begin
      bad_count++;
      $display("unexpected at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    // grants launched on the write edge still use the old enables
    @(posedge core_clk);
    if (a == ARB_REG_OFFSET)
      en_sh <= d[8:0];
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask
  // bounded wait for one grant line or the frame line
  task automatic wg(int i, logic v);
    t = 0;
    while (bv[i] !== v && t < 300)
    begin
      @(posedge core_clk);
      #1;
      t++;
    end
  endtask
  task automatic idle(int n);
    want <= 9'h000;
    repeat (n) @(posedge core_clk);
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(negedge core_clk)
  begin
    if (!rst)
    begin
      chk(32'($countones(~gnt_l) < 2), 1);
      chk({23'h0, ~gnt_l & pg & ~en_sh}, 0);
    end
    pg <= gnt_l;
  end
  initial
  begin
    #1000000;
    bad_count++;
    end_sim;
  end
  initial
  begin
    seed = 42807;
    {core_clk, reg_wr, reg_rd, want, dead, reg_wdata} = '0;
    {rst, pg, en_sh} = '1;
    reg_addr = ARB_REG_OFFSET;
    blen = 8'h04;
    r = $random(seed);
    strap = r[0];
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    repeat (6) @(posedge core_clk);
    rd(ARB_REG_OFFSET, rx(32'h0040_81FF));
    rd(8'h4C, 32'h0);
    wr(8'h4C, '1);
    rd(ARB_REG_OFFSET, rx(32'h0040_81FF));
    repeat (6)
    begin
      r = $random(seed);
      wr(ARB_REG_OFFSET, 32'(r));
      rd(ARB_REG_OFFSET, rx(32'(r)));
    end
    wr(ARB_REG_OFFSET, cfg(r[8:0], 4'h0, 8'h02, r[17:9]));
    repeat (30)
    begin
      r = $random(seed);
      want <= r[8:0];
      repeat (10) @(posedge core_clk);
    end
    idle(30);
    $display("test registers and random traffic done");
    wr(ARB_REG_OFFSET, cfg('1, 4'h1, 8'h08, 9'h001));
    dead <= 9'h008;
    want <= 9'h008;
    wg(3, 0);
    wg(3, 1);
    chk(32'(t >= 16 && t <= 18), 1);
    idle(4);
    dead <= 9'h000;
    want <= 9'h008;
    wg(3, 0);
    chk(t, 300);
    wr(ARB_REG_OFFSET, cfg(9'h028, 4'h3, 8'h08, 9'h001));
    want <= 9'h028;
    wg(3, 0);
    chk(32'(t < 300), 1);
    idle(30);
    $display("test broken master done");
    for (int k = 0; k < 3; k++)
    begin
      wr(ARB_REG_OFFSET, cfg('1, 4'h0, (k == 1) ? 8'h00 : 8'h04, 9'h001));
      dead <= (k == 2) ? 9'h002 : 9'h000;
      blen <= 8'd60;
      want <= 9'h002;
      wg(1, 0);
      if (k < 2)
        wg(9, 0);
      want <= 9'h006;
      wg(1, 1);
      if (k == 0)
        chk(32'(t >= 4 && t <= 12), 1);
      else if (k == 1)
        chk(32'(t > 50), 1);
      else
        chk(t, 300);
      idle(80);
    end
    dead <= 9'h000;
    $display("test fairness done");
    for (int k = 0; k < 2; k++)
    begin
      wr(ARB_REG_OFFSET, cfg('1, k ? 4'h4 : 4'h0, 8'h00, 9'h001));
      blen <= 8'd20;
      want <= 9'h040;
      wg(9, 0);
      r = 0;
      repeat (10)
      begin
        @(posedge core_clk);
        #1;
        r += int'(gnt_l[6]);
      end
      chk(32'(r), 32'(k));
      idle(40);
    end
    $display("test grant toggling done");
    wr(ARB_REG_OFFSET, cfg('1, 4'h0, 8'h08, 9'h080));
    want <= 9'h084;
    wg(7, 0);
    chk(32'(t < 12), 1);
    idle(60);
    $display("test priority done");
    end_sim;
  end
endmodule

// ===== shared/arb_pkg.sv
// constants and register layout of the secondary bus arbiter
//-------------------------------------------------------------
// Functional notes
// - enable bit 0 includes the internal request in arbitration; resets to one
// - enable bits 1..8 include external masters 1..8; each resets to one
// - read-only bit 9 shows the arbiter select strap level
// - timeout enable counts 16 idle cycles with grant waiting for frame; resets zero
// - timeout expiry before frame removes that master's grant
// - refresh off: broken master ignored forever after dropping request one clock
// - refresh on (bit 11): broken state cleared after all others served once
// - fairness field 19:12 preloads hold counter after competing request; resets 08h
// - fairness counter reloads on every new grant
// - counter starts decrementing after the next falling edge of frame
// - fairness zero keeps grant until granted master drops request
// - toggling off (bit 20, reset): grant stays on after frame asserted
// - toggling on: grant off one clock, two clocks after frame asserted
// - bits 22..30 set high priority; internal defaults high, masters low
//-------------------------------------------------------------
package arb_pkg;
  localparam logic [7:0] ARB_REG_OFFSET = 8'h48;
  localparam int EN_LSB = 0;
  localparam int STRAP_BIT = 9;
  localparam int TMO_EN_BIT = 10;
  localparam int REFRESH_BIT = 11;
  localparam int FAIR_LSB = 12;
  localparam int TOGGLE_BIT = 20;
  localparam int PRIO_LSB = 22;
  localparam logic [8:0] EN_RESET = 9'h1FF;
  localparam logic [7:0] FAIR_RESET = 8'h08;
  localparam logic [8:0] PRIO_RESET = 9'h001;
  localparam int TMO_CYCLES = 16;
  localparam int TOGGLE_DELAY = 2;
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_BUSY} arb_state_t;
endpackage
